// file: include/ws_addr_consts.vh
// Purpose: Constants for workspace operand addressing
// Assumes: 16-bit byte addresses, 16-bit memory words
// Notes:   Included by rtl/workspace_operand_addressing.v
`ifndef WS_ADDR_CONSTS_VH
`define WS_ADDR_CONSTS_VH

// =====================================================================
// Command codes
`define OP_FETCH      3'h0
`define OP_OPERAND    3'h1
`define OP_CTX_VECTOR 3'h2
`define OP_RESTORE    3'h3
`define OP_LOAD_WP    3'h4
`define OP_BRANCH_LINK 3'h5
`define OP_RET        3'h6
`define OP_NOP        3'h7

// =====================================================================
// Operand modes
`define MODE_DIRECT   2'h0
`define MODE_INDIRECT 2'h1
`define MODE_SYMBOLIC 2'h2
`define MODE_AUTOINC  2'h3

// =====================================================================
// Workspace layout and fixed values
`define WS_REG_COUNT  16
`define REG_LINK      4'hB
`define REG_SAVED_WP  4'hD
`define REG_SAVED_PC  4'hE
`define RESET_VECTOR  16'h0000
`define INC_WORD      16'h0002
`define INC_BYTE      16'h0001

`endif

// file: rtl/workspace_operand_addressing.v
// Purpose: Operand address generation for a memory-resident workspace CPU
// Assumes: Memory answers each request with a one-cycle ack on i_mclk
// Notes:   One command at a time; o_done pulses when a command completes
// Operation
// - Workspace is sixteen words, registers 0-15
// - Context switch loads base pointer from the first word read (vector word0 or saved R13)
// - Vector (also used for interrupts) and restore commands perform context switch
// - Load immediate replaces base pointer only
// - Direct mode: selected register holds operand
// - Indirect mode: register holds address, unchanged
// - Branch-and-link writes next-word address to R11
// - Symbolic mode: extension word gives address
// - No-op is jump to next instruction
// - Return branches through R11 contents
// - Vector word0 to base pointer, word1 PC
// - Direct byte ops use left byte
// - PC points past current instruction
// - Indexed mode adds register to extension address
// - Autoincrement adds two (word) or one (byte)
`timescale 1ns/1ps
`default_nettype none
`include "ws_addr_consts.vh"

module workspace_operand_addressing #(
    parameter AW = 16
) (
    input  wire          i_mclk,
    input  wire          i_sys_rst,
    input  wire          i_cmd_valid,
    input  wire [2:0]    i_cmd_op,
    input  wire [1:0]    i_mode,
    input  wire [3:0]    i_reg,
    input  wire          i_byte,
    input  wire [AW-1:0] i_vec_addr,
    input  wire [AW-1:0] i_wp_imm,
    input  wire [AW-1:0] i_target,
    input  wire          i_mem_ack,
    input  wire [15:0]   i_mem_rdata,
    output wire          o_cmd_ready,
    output wire          o_done,
    output wire [AW-1:0] o_ea,
    output wire [15:0]   o_operand,
    output wire          o_byte_hi,
    output wire [AW-1:0] o_wp,
    output wire [AW-1:0] o_pc,
    output wire          o_mem_req,
    output wire          o_mem_we,
    output wire [AW-1:0] o_mem_addr,
    output wire [15:0]   o_mem_wdata
);

    // =================================================================
    // States, one-hot
    localparam [7:0] S_IDLE = 8'h01;
    localparam [7:0] S_EXT  = 8'h02;
    localparam [7:0] S_REG  = 8'h04;
    localparam [7:0] S_WB   = 8'h08;
    localparam [7:0] S_OPND = 8'h10;
    localparam [7:0] S_VEC0 = 8'h20;
    localparam [7:0] S_VEC1 = 8'h40;
    localparam [7:0] S_LINK = 8'h80;

    reg [7:0]    state_reg;
    reg [2:0]    op_reg;
    reg [1:0]    mode_reg;
    reg [3:0]    rnum_reg;
    reg          byte_reg;
    reg [AW-1:0] wp_reg;
    reg [AW-1:0] pc_reg;
    reg [AW-1:0] ea_reg;
    reg [AW-1:0] tmp_reg;
    reg [15:0]   operand_reg;
    reg          byte_hi_reg;
    reg          done_reg;
    reg          ready_reg;
    reg          req_reg;
    reg          we_reg;
    reg [AW-1:0] addr_reg;
    reg [15:0]   wdata_reg;

    // =================================================================
    // Register address decode, shared by every workspace access except the restore's saved-PC (R14) read
    function [AW-1:0] reg_addr;
        input [AW-1:0] base;
        input [3:0]    n;
        begin
            reg_addr = base + {{(AW-5){1'b0}}, n, 1'b0};
        end
    endfunction

    // Word-aligned memory address; byte lane is reported separately
    function [AW-1:0] word_addr;
        input [AW-1:0] a;
        begin
            word_addr = {a[AW-1:1], 1'b0};
        end
    endfunction

    wire          mem_done = req_reg & i_mem_ack;
    wire [AW-1:0] rdata_a  = i_mem_rdata[AW-1:0];
    wire [AW-1:0] inc_val  = byte_reg ? `INC_BYTE : `INC_WORD;

    // =================================================================
    // Sequencer: every memory access holds req until ack
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            // Power-up starts with a context switch through the reset vector
            state_reg   <= S_VEC0;
            op_reg      <= `OP_CTX_VECTOR;
            mode_reg    <= `MODE_DIRECT;
            rnum_reg    <= 4'h0;
            byte_reg    <= 1'b0;
            wp_reg      <= {AW{1'b0}};
            pc_reg      <= {AW{1'b0}};
            ea_reg      <= {AW{1'b0}};
            tmp_reg     <= {AW{1'b0}};
            operand_reg <= 16'h0000;
            byte_hi_reg <= 1'b0;
            done_reg    <= 1'b0;
            ready_reg   <= 1'b0;
            req_reg     <= 1'b1;
            we_reg      <= 1'b0;
            addr_reg    <= `RESET_VECTOR;
            wdata_reg   <= 16'h0000;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (i_cmd_valid) begin
                        ready_reg <= 1'b0;
                        op_reg    <= i_cmd_op;
                        mode_reg  <= i_mode;
                        rnum_reg  <= i_reg;
                        byte_reg  <= i_byte;
                        case (i_cmd_op)
                            `OP_FETCH: begin
                                state_reg <= S_EXT;
                                req_reg   <= 1'b1;
                                addr_reg  <= word_addr(pc_reg);
                            end
                            `OP_OPERAND: begin
                                req_reg <= 1'b1;
                                if (i_mode == `MODE_SYMBOLIC) begin
                                    // Extension word sits at PC
                                    state_reg <= S_EXT;
                                    addr_reg  <= word_addr(pc_reg);
                                end else if (i_mode == `MODE_DIRECT) begin
                                    // Register itself is the operand
                                    state_reg   <= S_OPND;
                                    ea_reg      <= reg_addr(wp_reg, i_reg);
                                    addr_reg    <= reg_addr(wp_reg, i_reg);
                                    byte_hi_reg <= 1'b1;
                                end else begin
                                    state_reg <= S_REG;
                                    addr_reg  <= reg_addr(wp_reg, i_reg);
                                end
                            end
                            `OP_CTX_VECTOR: begin
                                // Vector command also serves interrupts and traps
                                state_reg <= S_VEC0;
                                req_reg   <= 1'b1;
                                addr_reg  <= word_addr(i_vec_addr);
                                tmp_reg   <= word_addr(i_vec_addr);
                            end
                            `OP_RESTORE: begin
                                // Old base and PC come from saved slots of this workspace
                                state_reg <= S_VEC0;
                                req_reg   <= 1'b1;
                                addr_reg  <= reg_addr(wp_reg, `REG_SAVED_WP);
                                tmp_reg   <= reg_addr(wp_reg, `REG_SAVED_WP);
                            end
                            `OP_LOAD_WP: begin
                                // No memory traffic: only the base pointer moves
                                wp_reg    <= i_wp_imm;
                                done_reg  <= 1'b1;
                                ready_reg <= 1'b1;
                            end
                            `OP_BRANCH_LINK: begin
                                // PC already points past the instruction
                                state_reg <= S_LINK;
                                req_reg   <= 1'b1;
                                we_reg    <= 1'b1;
                                addr_reg  <= reg_addr(wp_reg, `REG_LINK);
                                wdata_reg <= {{(16-AW){1'b0}}, pc_reg};
                            end
                            `OP_RET: begin
                                state_reg <= S_REG;
                                req_reg   <= 1'b1;
                                rnum_reg  <= `REG_LINK;
                                addr_reg  <= reg_addr(wp_reg, `REG_LINK);
                            end
                            default: begin
                                // Jump to next word: PC is left as it stands
                                done_reg  <= 1'b1;
                                ready_reg <= 1'b1;
                            end
                        endcase
                    end
                end
                S_EXT: begin
                    if (mem_done) begin
                        pc_reg <= pc_reg + `INC_WORD;
                        if (op_reg == `OP_FETCH) begin
                            operand_reg <= i_mem_rdata;
                            req_reg     <= 1'b0;
                            state_reg   <= S_IDLE;
                            done_reg    <= 1'b1;
                            ready_reg   <= 1'b1;
                        end else if (rnum_reg != 4'h0) begin
                            // Indexed: register 0 cannot index
                            ea_reg    <= rdata_a;
                            state_reg <= S_REG;
                            addr_reg  <= reg_addr(wp_reg, rnum_reg);
                        end else begin
                            ea_reg      <= rdata_a;
                            byte_hi_reg <= ~rdata_a[0];
                            state_reg   <= S_OPND;
                            addr_reg    <= word_addr(rdata_a);
                        end
                    end
                end
                S_REG: begin
                    if (mem_done) begin
                        if (op_reg == `OP_RET) begin
                            pc_reg    <= rdata_a;
                            req_reg   <= 1'b0;
                            state_reg <= S_IDLE;
                            done_reg  <= 1'b1;
                            ready_reg <= 1'b1;
                        end else if (mode_reg == `MODE_SYMBOLIC) begin
                            ea_reg      <= ea_reg + rdata_a;
                            byte_hi_reg <= ~(ea_reg[0] ^ rdata_a[0]);
                            state_reg   <= S_OPND;
                            addr_reg    <= word_addr(ea_reg + rdata_a);
                        end else if (mode_reg == `MODE_AUTOINC) begin
                            // Bump the register before the operand read
                            ea_reg      <= rdata_a;
                            byte_hi_reg <= ~rdata_a[0];
                            state_reg   <= S_WB;
                            we_reg      <= 1'b1;
                            wdata_reg   <= {{(16-AW){1'b0}}, rdata_a + inc_val};
                        end else begin
                            // Register is only read, never written back
                            ea_reg      <= rdata_a;
                            byte_hi_reg <= ~rdata_a[0];
                            state_reg   <= S_OPND;
                            addr_reg    <= word_addr(rdata_a);
                        end
                    end
                end
                S_WB: begin
                    if (mem_done) begin
                        we_reg    <= 1'b0;
                        state_reg <= S_OPND;
                        addr_reg  <= word_addr(ea_reg);
                    end
                end
                S_OPND: begin
                    if (mem_done) begin
                        operand_reg <= i_mem_rdata;
                        req_reg     <= 1'b0;
                        state_reg   <= S_IDLE;
                        done_reg    <= 1'b1;
                        ready_reg   <= 1'b1;
                    end
                end
                S_VEC0: begin
                    if (mem_done) begin
                        // Hold new base aside until the PC word is in
                        ea_reg    <= rdata_a;
                        state_reg <= S_VEC1;
                        addr_reg  <= tmp_reg + `INC_WORD;
                    end
                end
                S_VEC1: begin
                    if (mem_done) begin
                        wp_reg    <= ea_reg;
                        pc_reg    <= rdata_a;
                        req_reg   <= 1'b0;
                        state_reg <= S_IDLE;
                        done_reg  <= 1'b1;
                        ready_reg <= 1'b1;
                    end
                end
                S_LINK: begin
                    if (mem_done) begin
                        pc_reg    <= i_target;
                        req_reg   <= 1'b0;
                        we_reg    <= 1'b0;
                        state_reg <= S_IDLE;
                        done_reg  <= 1'b1;
                        ready_reg <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                    req_reg   <= 1'b0;
                    we_reg    <= 1'b0;
                    ready_reg <= 1'b1;
                end
            endcase
        end
    end

    // =================================================================
    // Outputs, all straight from flops
    assign o_cmd_ready = ready_reg;
    assign o_done      = done_reg;
    assign o_ea        = ea_reg;
    assign o_operand   = operand_reg;
    assign o_byte_hi   = byte_hi_reg;
    assign o_wp        = wp_reg;
    assign o_pc        = pc_reg;
    assign o_mem_req   = req_reg;
    assign o_mem_we    = we_reg;
    assign o_mem_addr  = addr_reg;
    assign o_mem_wdata = wdata_reg;

endmodule // workspace_operand_addressing

`default_nettype wire

// file: test/ws_addr_chk.sv
// Purpose: Port checker for workspace operand addressing
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module after endmodule
`timescale 1ns/1ps
`default_nettype none
`include "ws_addr_consts.vh"
module ws_addr_chk (
    input wire logic        i_mclk,
    input wire logic        i_sys_rst,
    input wire logic        i_cmd_valid,
    input wire logic [2:0]  i_cmd_op,
    input wire logic [1:0]  i_mode,
    input wire logic [3:0]  i_reg,
    input wire logic [15:0] i_vec_addr,
    input wire logic [15:0] i_wp_imm,
    input wire logic        o_cmd_ready,
    input wire logic        o_done,
    input wire logic [15:0] o_wp,
    input wire logic [15:0] o_pc,
    input wire logic        o_mem_req,
    input wire logic        o_mem_we,
    input wire logic [15:0] o_mem_addr,
    input wire logic [15:0] o_mem_wdata
);
    // ==========================================================
    // Command acceptance
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    sequence s_take(logic [2:0] op);
        o_cmd_ready && i_cmd_valid && i_cmd_op == op;
    endsequence
    sequence s_opnd(logic [1:0] m);
        s_take(`OP_OPERAND) ##0 i_mode == m;
    endsequence
    // ==========================================================
    // First access, or completion, of each command except fetch
    AST_CTX_WP: assert property (s_take(`OP_CTX_VECTOR) |=>
        o_mem_req && !o_mem_we && o_mem_addr == $past(i_vec_addr)) else $error("vector read address");
    AST_RESTORE: assert property (s_take(`OP_RESTORE) |=>
        !o_mem_we && o_mem_addr == $past(o_wp) + 16'h001A) else $error("restore reads wrong word");
    AST_LOAD_WP: assert property (s_take(`OP_LOAD_WP) |=>
        o_done && o_wp == $past(i_wp_imm) && $stable(o_pc)) else $error("load pointer wrong");
    AST_DIRECT: assert property (s_opnd(`MODE_DIRECT) |=>
        o_mem_req && o_mem_addr == $past(o_wp) + {11'h000, $past(i_reg), 1'b0}) else $error("register address");
    AST_INDIRECT: assert property (s_opnd(`MODE_INDIRECT) |=>
        !o_mem_we [*2]) else $error("indirect mode wrote memory");
    AST_SYMBOLIC: assert property (s_opnd(`MODE_SYMBOLIC) ##0 i_reg == 4'h0 |=>
        !o_mem_we && o_mem_addr == $past(o_pc)) else $error("extension word address");
    AST_BRANCH_LINK: assert property (s_take(`OP_BRANCH_LINK) |=>
        o_mem_we && o_mem_addr == $past(o_wp) + 16'h0016 && o_mem_wdata == $past(o_pc)) else $error("link");
    AST_RETURN: assert property (s_take(`OP_RET) |=>
        !o_mem_we && o_mem_addr == $past(o_wp) + 16'h0016) else $error("return reads wrong word");
    AST_NOP: assert property (s_take(`OP_NOP) |=>
        o_done && $stable(o_pc) && $stable(o_wp)) else $error("no-op changed state");
endmodule // ws_addr_chk
bind workspace_operand_addressing ws_addr_chk i_ws_addr_chk (.*);
`default_nettype wire

// file: test/mem_model.sv
// Purpose: Behavioural main memory for the workspace block
// Assumes: One ack pulse per request, data valid with ack
// Notes:   Latency from i_lat; idle read data toggles
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic [3:0]  i_lat,
    output var  logic        o_ack,
    output var  logic [15:0] o_rdata
);
    logic [15:0] mem [0:511];
    logic [3:0]  wait_reg;
    // ==========================================================
    // Start state
    initial begin
        o_ack = 1'b0;
        o_rdata = 16'h0000;
        wait_reg = 4'h0;
    end
    // Ack after i_lat cycles; stale data never looks valid
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack) begin
            if (wait_reg >= i_lat) begin
                o_ack <= 1'b1;
                wait_reg <= 4'h0;
                if (i_we) mem[i_addr[9:1]] <= i_wdata;
                else o_rdata <= mem[i_addr[9:1]];
            end else wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule // mem_model
`default_nettype wire

// file: test/test_workspace_operand_addressing.sv
// Purpose: Self-checking bench for workspace operand addressing
// Assumes: Inputs change at the falling edge
// Notes:   Memory contents set and read by backdoor
`timescale 1ns/1ps
`default_nettype none
`include "ws_addr_consts.vh"
module test_workspace_operand_addressing;
    logic clk = 0, rst = 1, vld = 0, byt = 0, ack, rdy, dn, bh, mrq, mwe;
    logic [2:0]  op = 0;
    logic [1:0]  md = 0;
    logic [3:0]  rg = 0, lat = 0;
    logic [15:0] vec = 0, imm = 0, tgt = 0, rdat, ea, opd, wp, pc, ma, wd;
    int          miscompares = 0, samples_checked = 0;
    // ==========================================================
    // Clock and instances
    always #5 clk = ~clk;
    workspace_operand_addressing i_workspace_operand_addressing (
        .i_mclk(clk), .i_sys_rst(rst), .i_cmd_valid(vld), .i_cmd_op(op),
        .i_mode(md), .i_reg(rg), .i_byte(byt), .i_vec_addr(vec),
        .i_wp_imm(imm), .i_target(tgt), .i_mem_ack(ack), .i_mem_rdata(rdat),
        .o_cmd_ready(rdy), .o_done(dn), .o_ea(ea), .o_operand(opd),
        .o_byte_hi(bh), .o_wp(wp), .o_pc(pc), .o_mem_req(mrq),
        .o_mem_we(mwe), .o_mem_addr(ma), .o_mem_wdata(wd));
    mem_model i_mem_model (.i_clk(clk), .i_req(mrq), .i_we(mwe), .i_addr(ma),
        .i_wdata(wd), .i_lat(lat), .o_ack(ack), .o_rdata(rdat));
    // ==========================================================
    // Shared tasks
    task test_done;
        if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            $display("Error at %0t: saw %h, wanted %h", $time, g, e);
            miscompares++;
        end
    endtask
    task wr(input logic [15:0] a, input logic [15:0] d);
        i_mem_model.mem[a[9:1]] = d;
    endtask
    function automatic logic [15:0] rd(input logic [15:0] a);
        return i_mem_model.mem[a[9:1]];
    endfunction
    // Bounded wait, so a lost done cannot hang the run
    task wait_done;
        int n;
        n = 0;
        while (dn !== 1'b1 && n < 40) begin
            n++;
            @(negedge clk);
        end
        if (n >= 40) begin
            miscompares++;
            test_done;
        end
    endtask
    task run(input logic [2:0] o, input logic [1:0] m, input logic [3:0] r, input logic b);
        int n;
        n = 0;
        @(negedge clk);
        while (rdy !== 1'b1 && n < 40) begin
            n++;
            @(negedge clk);
        end
        // A block that never comes ready must not pass silently
        if (n >= 40) begin
            miscompares++;
            test_done;
        end
        vld = 1;
        op = o;
        md = m;
        rg = r;
        byt = b;
        @(negedge clk);
        vld = 0;
        wait_done;
    endtask
    // ==========================================================
    // Scenarios
    task s_ctx;
        wr(16'h0040, 16'h0140);
        wr(16'h0042, 16'h0300);
        vec = 16'h0040;
        run(`OP_CTX_VECTOR, 0, 0, 0);
        chk(wp, 16'h0140);
        chk(pc, 16'h0300);
        wr(16'h015A, 16'h0100);
        wr(16'h015C, 16'h0204);
        run(`OP_RESTORE, 0, 0, 0);
        chk(wp, 16'h0100);
        chk(pc, 16'h0204);
        imm = 16'h0140;
        run(`OP_LOAD_WP, 0, 0, 0);
        chk(wp, 16'h0140);
        chk(pc, 16'h0204);
        imm = 16'h0100;
        run(`OP_LOAD_WP, 0, 0, 0);
    endtask
    task s_direct;
        lat = 1;
        for (int n = 0; n < 16; n++) begin
            wr(16'h0100 + 2 * n, 16'h1000 + n);
            run(`OP_OPERAND, `MODE_DIRECT, n, 1);
            chk(opd, 16'h1000 + n);
            chk(ea, 16'h0100 + 2 * n);
            chk({15'h0000, bh}, 16'h0001);
        end
    endtask
    // Slow memory here, to stretch every handshake
    task s_indirect;
        lat = 3;
        wr(16'h010E, 16'h0180);
        wr(16'h0180, 16'hABCD);
        run(`OP_OPERAND, `MODE_INDIRECT, 7, 0);
        chk(opd, 16'hABCD);
        chk(ea, 16'h0180);
        chk(rd(16'h010E), 16'h0180);
        run(`OP_OPERAND, `MODE_AUTOINC, 7, 0);
        chk(opd, 16'hABCD);
        chk(rd(16'h010E), 16'h0182);
        run(`OP_OPERAND, `MODE_AUTOINC, 7, 1);
        chk(rd(16'h010E), 16'h0183);
        // Odd pointer: right byte, word-aligned operand read
        wr(16'h0182, 16'h1357);
        run(`OP_OPERAND, `MODE_AUTOINC, 7, 1);
        chk(opd, 16'h1357);
        chk({15'h0000, bh}, 16'h0000);
        chk(ea, 16'h0183);
        chk(rd(16'h010E), 16'h0184);
        lat = 0;
    endtask
    task s_memory;
        wr(16'h0204, 16'h01A0);
        wr(16'h01A0, 16'h5A5A);
        run(`OP_OPERAND, `MODE_SYMBOLIC, 0, 0);
        chk(opd, 16'h5A5A);
        chk(pc, 16'h0206);
        wr(16'h0110, 16'h0004);
        wr(16'h0206, 16'h01A0);
        wr(16'h01A4, 16'h3C3C);
        run(`OP_OPERAND, `MODE_SYMBOLIC, 8, 0);
        chk(ea, 16'h01A4);
        chk(opd, 16'h3C3C);
    endtask
    task s_branch;
        wr(16'h0208, 16'h1234);
        run(`OP_FETCH, 0, 0, 0);
        chk(opd, 16'h1234);
        chk(pc, 16'h020A);
        tgt = 16'h0250;
        run(`OP_BRANCH_LINK, 0, 0, 0);
        chk(rd(16'h0116), 16'h020A);
        chk(pc, 16'h0250);
        run(`OP_RET, 0, 0, 0);
        chk(pc, 16'h020A);
        run(`OP_NOP, 0, 0, 0);
        chk(pc, 16'h020A);
        chk(wp, 16'h0100);
    endtask
    // ==========================================================
    // Main sequence: power-up vector, then each scenario
    initial begin
        wr(16'h0000, 16'h0100);
        wr(16'h0002, 16'h0200);
        repeat (4) @(negedge clk);
        rst = 0;
        wait_done;
        chk(wp, 16'h0100);
        chk(pc, 16'h0200);
        s_ctx;
        s_direct;
        s_indirect;
        s_memory;
        s_branch;
        test_done;
    end
endmodule // test_workspace_operand_addressing
`default_nettype wire
